//--- src/vic_defines.svh
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_NSRC        32
`define VIC_ADDR_W      9
// register byte offsets
`define VIC_OFS_SMR0    9'h000
`define VIC_OFS_SVR0    9'h080
`define VIC_OFS_NVR     9'h100
`define VIC_OFS_FVR     9'h104
`define VIC_OFS_CSR     9'h108
`define VIC_OFS_PEND    9'h10C
`define VIC_OFS_MASK    9'h110
`define VIC_OFS_CORE    9'h114
`define VIC_OFS_IEN     9'h120
`define VIC_OFS_IDIS    9'h124
`define VIC_OFS_CLR     9'h128
`define VIC_OFS_SET     9'h12C
`define VIC_OFS_EOS     9'h130
`define VIC_OFS_SPU     9'h134
`define VIC_OFS_DBG     9'h138
`define VIC_OFS_FFEN    9'h140
`define VIC_OFS_FFDIS   9'h144
`define VIC_OFS_FFST    9'h148
`define VIC_OFS_WGMODE  9'h1E4
`define VIC_OFS_WGSTAT  9'h1E8
// field positions
`define VIC_DBG_PROTECT_MODE_BIT    0
`define VIC_DBG_GLOBAL_MASK_BIT    1
`define VIC_WG_EN       0
`define VIC_WG_VFLAG    0
`define VIC_WG_SRC_LSB  8
`define VIC_SMR_TYPE_LSB 5
`define VIC_RST_WORD    32'h0000_0000

`endif

//--- src/vic_pkg.sv
package vic_pkg;
   typedef enum logic [1:0] {
      VIC_SRC_LOW_LEVEL,
      VIC_SRC_NEG_EDGE,
      VIC_SRC_HIGH_LEVEL,
      VIC_SRC_POS_EDGE
   } vic_src_type_t;
   typedef enum {
      VIC_IDLE,
      VIC_HELD
   } vic_ack_state_t;
endpackage : vic_pkg

//--- src/vic_src_detect.sv
`timescale 1ns/10ps
module vic_src_detect
   import vic_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       src_in,
   input  wire logic [1:0] src_type,
   input  wire logic       set_cmd,
   input  wire logic       clr_cmd,
   output logic            pending
);
   logic prev_q;
   logic edge_q;
   logic is_edge;
   logic lvl;
   logic hit;

   assign is_edge = (src_type == VIC_SRC_NEG_EDGE)
                    || (src_type == VIC_SRC_POS_EDGE);
   assign lvl     = (src_type == VIC_SRC_LOW_LEVEL)
                    || (src_type == VIC_SRC_NEG_EDGE) ? ~src_in : src_in;

   // starts high so no false edge follows reset
   always_ff @(posedge clk) begin
      if (rst) prev_q <= 1'b1;
      else prev_q <= lvl;
   end

   // only edge types capture; a level type must not leave a stale edge
   assign hit = is_edge && lvl && !prev_q;

   // detected edge wins over a same-cycle clear
   always_ff @(posedge clk) begin
      if (rst) edge_q <= 1'b0;
      else if (hit || set_cmd) edge_q <= 1'b1;
      else if (clr_cmd) edge_q <= 1'b0;
   end

   assign pending = is_edge ? edge_q : lvl;
endmodule : vic_src_detect

//--- src/vic_prio_pick.sv
`timescale 1ns/10ps
module vic_prio_pick
   import vic_pkg::*;
(
   input  wire logic [31:0] cand,
   input  wire logic [95:0] prio_flat,
   output logic             found,
   output logic [4:0]       idx,
   output logic [2:0]       level
);
   // highest level wins, lowest index breaks ties
   always_comb begin
      found = 1'b0;
      idx   = 5'd0;
      level = 3'd0;
      for (int i = 31; i >= 1; i--) begin
         if (cand[i] && (!found || prio_flat[i*3 +: 3] >= level)) begin
            found = 1'b1;
            idx   = 5'(i);
            level = prio_flat[i*3 +: 3];
         end
      end
   end
endmodule : vic_prio_pick

//--- src/vic_ctrl.sv
// Notes on behaviour
// - fast forcing status per source; enable command sets, disable clears
// - forced sources keep detection but never reach priority or normal line
// - forced level source at active level asserts fast request
// - forced edge source with detected edge asserts fast request
// - forcing leaves source zero pending bit untouched
// - fast vector read always returns source zero vector
// - with forcing in use, fast vector read does not clear source zero
// - normal vector read never clears a forced source
// - source zero stays a fast source alongside forced sources
// - protect bit at one enables protect mode
// - in protect mode stacking and status update happen at vector write
// - in protect mode vector reads alone change no context
// - normal vector read picks, returns, memorizes, pushes, acknowledges
// - protect read does steps one to three; write pushes and acknowledges
// - vector read with nothing pending returns spurious vector
// - global mask holds both request lines inactive
// - global mask does not block idle wake-up
// - guard rejects writes to mode, vector, spurious, debug registers
// - rejected write sets violation flag and records target register
// - reading write guard status clears violation flag
// - normal vector read drops request and clears edge current source
// - end of service pops level stack, restoring previous level
`timescale 1ns/10ps
`include "vic_defines.svh"
module vic_ctrl
   import vic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [31:0] src_in,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [8:0]  addr,
   input  wire logic [31:0] wdata,
   output logic [31:0]      rdata,
   output logic             normal_request_n,
   output logic             fast_request_n,
   output logic             wake_up
);
   logic [2:0]  smr_q [32];
   logic [1:0]  styp_q [32];
   logic [31:0] svr_q [32];
   logic [31:0] spu_q;
   logic [1:0]  dbg_q;
   logic        wg_en_q;
   logic        wg_vflag_q;
   logic [8:0]  wg_vsrc_q;
   logic [31:0] ien_q;
   logic [31:0] force_fast_status_q;
   logic [4:0]  cur_q;
   logic [2:0]  cur_lvl_q;
   logic [7:0]  stk_valid_q;
   logic [2:0]  stk_lvl_q [8];
   logic [4:0]  stk_src_q [8];
   logic [4:0]  memo_src_q;
   logic        memo_spur_q;
   logic [31:0] rdata_q;
   logic [31:0] pending_status;
   logic [31:0] is_edge;
   logic [31:0] set_cmd;
   logic [31:0] clr_cmd;
   logic [31:0] cand;
   logic [95:0] prio_flat;
   logic        found;
   logic [4:0]  pick_idx;
   logic [2:0]  pick_lvl;
   logic        above;
   logic        protect_mode_bit;
   logic        global_mask_bit;
   logic        guarded;
   logic        wr_guarded;
   logic        ack_now;
   logic [4:0]  ack_src;
   logic        ack_spur;
   logic        pop_now;
   logic [31:0] fast_src;
   vic_ack_state_t ack_st_q;

   assign protect_mode_bit = dbg_q[`VIC_DBG_PROTECT_MODE_BIT];
   assign global_mask_bit  = dbg_q[`VIC_DBG_GLOBAL_MASK_BIT];

   // one detector per source; its type comes from mode bits 6:5
   for (genvar g = 0; g < 32; g++) begin : g_src
      assign is_edge[g] = styp_q[g][0];
      assign prio_flat[g*3 +: 3] = smr_q[g];
      vic_src_detect u_det (
         .clk      (clk),
         .rst      (rst),
         .src_in   (src_in[g]),
         .src_type (styp_q[g]),
         .set_cmd  (set_cmd[g]),
         .clr_cmd  (clr_cmd[g]),
         .pending  (pending_status[g])
      );
   end

   // write guard decode
   assign guarded = (addr < `VIC_OFS_NVR) || (addr == `VIC_OFS_SPU)
                    || (addr == `VIC_OFS_DBG);
   assign wr_guarded = wr_en && wg_en_q && guarded;

   // forced sources leave the priority logic; source 0 has none
   assign cand = pending_status & ien_q & ~force_fast_status_q
                 & 32'hFFFF_FFFE;

   vic_prio_pick u_pick (
      .cand      (cand),
      .prio_flat (prio_flat),
      .found     (found),
      .idx       (pick_idx),
      .level     (pick_lvl)
   );

   // the pick must outrank the level now being served
   assign above = found && (!(|stk_valid_q) || ack_st_q == VIC_IDLE
                            ? 1'b1 : pick_lvl > cur_lvl_q);

   // acknowledge: read in normal mode, write in protect mode
   assign ack_now  = (addr == `VIC_OFS_NVR) &&
                     (protect_mode_bit ? wr_en : rd_en);
   assign ack_src  = protect_mode_bit ? memo_src_q : pick_idx;
   // a spurious acknowledge neither pushes nor clears
   assign ack_spur = protect_mode_bit ? memo_spur_q : !above;
   assign pop_now  = wr_en && addr == `VIC_OFS_EOS;

   // command strobes into detectors
   always_comb begin
      set_cmd = 32'h0000_0000;
      clr_cmd = 32'h0000_0000;
      if (wr_en && addr == `VIC_OFS_SET) set_cmd = wdata;
      if (wr_en && addr == `VIC_OFS_CLR) clr_cmd = wdata;
      // auto clear of edge current source, never a forced one
      if (ack_now && !ack_spur && is_edge[ack_src]
          && !force_fast_status_q[ack_src]) begin
         clr_cmd[ack_src] = 1'b1;
      end
      // fast vector read clears source 0 only when forcing is unused
      if (rd_en && addr == `VIC_OFS_FVR && is_edge[0]
          && !(|force_fast_status_q)) begin
         clr_cmd[0] = 1'b1;
      end
   end

   // mode and vector registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 32; i++) begin
            smr_q[i]  <= 3'd0;
            styp_q[i] <= 2'd0;
            svr_q[i]  <= `VIC_RST_WORD;
         end
         spu_q <= `VIC_RST_WORD;
         dbg_q <= 2'd0;
      end else if (wr_en && !wr_guarded) begin
         if (addr < `VIC_OFS_SVR0) begin
            smr_q[addr[6:2]]  <= wdata[2:0];
            styp_q[addr[6:2]] <= wdata[`VIC_SMR_TYPE_LSB +: 2];
         end else if (addr < `VIC_OFS_NVR) begin
            svr_q[addr[6:2]] <= wdata;
         end else if (addr == `VIC_OFS_SPU) begin
            spu_q <= wdata;
         end else if (addr == `VIC_OFS_DBG) begin
            dbg_q <= wdata[1:0];
         end
      end
   end

   // enable mask and fast forcing
   always_ff @(posedge clk) begin
      if (rst) begin
         ien_q <= 32'h0000_0000;
         force_fast_status_q <= 32'h0000_0000;
      end else if (wr_en) begin
         if (addr == `VIC_OFS_IEN) ien_q <= ien_q | wdata;
         if (addr == `VIC_OFS_IDIS) ien_q <= ien_q & ~wdata;
         if (addr == `VIC_OFS_FFEN)
            force_fast_status_q <= force_fast_status_q | wdata;
         if (addr == `VIC_OFS_FFDIS)
            force_fast_status_q <= force_fast_status_q & ~wdata;
      end
   end

   // write guard mode and status
   always_ff @(posedge clk) begin
      if (rst) begin
         wg_en_q    <= 1'b0;
         wg_vflag_q <= 1'b0;
         wg_vsrc_q  <= 9'd0;
      end else begin
         if (wr_en && addr == `VIC_OFS_WGMODE) wg_en_q <= wdata[`VIC_WG_EN];
         // a violation outranks the clearing read in the same cycle
         if (wr_guarded) begin
            wg_vflag_q <= 1'b1;
            wg_vsrc_q  <= addr;
         end else if (rd_en && addr == `VIC_OFS_WGSTAT) begin
            wg_vflag_q <= 1'b0;
         end
      end
   end

   // memorized interrupt from a vector read
   // protect mode relies on this memo at the later vector write
   always_ff @(posedge clk) begin
      if (rst) begin
         memo_src_q  <= 5'd0;
         memo_spur_q <= 1'b1;
      end else if (rd_en && addr == `VIC_OFS_NVR) begin
         memo_src_q  <= pick_idx;
         memo_spur_q <= !above;
      end
   end

   // priority stack: push on acknowledge, pop on end of service
   // depth 8; a push on a full stack drops the oldest level
   always_ff @(posedge clk) begin
      if (rst) begin
         stk_valid_q <= 8'h00;
         cur_q       <= 5'd0;
         cur_lvl_q   <= 3'd0;
         ack_st_q    <= VIC_IDLE;
         for (int i = 0; i < 8; i++) begin
            stk_lvl_q[i] <= 3'd0;
            stk_src_q[i] <= 5'd0;
         end
      end else if (ack_now && !ack_spur) begin
         stk_valid_q <= {stk_valid_q[6:0], 1'b1};
         stk_lvl_q[0] <= cur_lvl_q;
         stk_src_q[0] <= cur_q;
         for (int i = 1; i < 8; i++) begin
            stk_lvl_q[i] <= stk_lvl_q[i-1];
            stk_src_q[i] <= stk_src_q[i-1];
         end
         cur_q     <= ack_src;
         cur_lvl_q <= smr_q[ack_src];
         ack_st_q  <= VIC_HELD;
      end else if (pop_now && stk_valid_q[0]) begin
         stk_valid_q <= {1'b0, stk_valid_q[7:1]};
         cur_lvl_q   <= stk_lvl_q[0];
         cur_q       <= stk_src_q[0];
         for (int i = 0; i < 7; i++) begin
            stk_lvl_q[i] <= stk_lvl_q[i+1];
            stk_src_q[i] <= stk_src_q[i+1];
         end
         if (!stk_valid_q[1]) ack_st_q <= VIC_IDLE;
      end
   end

   // read data
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= `VIC_RST_WORD;
      end else if (rd_en) begin
         if (addr < `VIC_OFS_SVR0)
            // type back at bits 6:5, priority at 2:0, as written
            rdata_q <= {25'd0, styp_q[addr[6:2]], 2'd0, smr_q[addr[6:2]]};
         else if (addr < `VIC_OFS_NVR)
            rdata_q <= svr_q[addr[6:2]];
         else case (addr)
            `VIC_OFS_NVR:
               rdata_q <= above ? svr_q[pick_idx] : spu_q;
            `VIC_OFS_FVR:    rdata_q <= svr_q[0];
            `VIC_OFS_CSR:    rdata_q <= {27'd0, cur_q};
            `VIC_OFS_PEND:   rdata_q <= pending_status;
            `VIC_OFS_MASK:   rdata_q <= ien_q;
            `VIC_OFS_CORE:
               rdata_q <= {30'd0, !normal_request_n, !fast_request_n};
            `VIC_OFS_SPU:    rdata_q <= spu_q;
            `VIC_OFS_DBG:    rdata_q <= {30'd0, dbg_q};
            `VIC_OFS_FFST:   rdata_q <= force_fast_status_q;
            `VIC_OFS_WGMODE: rdata_q <= {31'd0, wg_en_q};
            `VIC_OFS_WGSTAT:
               rdata_q <= {15'd0, wg_vsrc_q, 7'd0, wg_vflag_q};
            default:         rdata_q <= `VIC_RST_WORD;
         endcase
      end
   end
   assign rdata = rdata_q;

   // fast request sources: source 0 plus forced sources
   assign fast_src = pending_status & ien_q
                     & (force_fast_status_q | 32'h0000_0001);

   // request lines and idle wake-up
   // registered so the lines never glitch toward the core
   always_ff @(posedge clk) begin
      if (rst) begin
         normal_request_n <= 1'b1;
         fast_request_n   <= 1'b1;
         wake_up          <= 1'b0;
      end else begin
         normal_request_n <= !(above && !ack_now && !global_mask_bit)
                             ;
         fast_request_n   <= !((|fast_src) && !global_mask_bit)
                             ;
         wake_up          <= (|cand) || (|fast_src);
      end
   end
endmodule : vic_ctrl

//--- tb/vic_ctrl_checker.sv
`timescale 1ns/10ps
`include "vic_defines.svh"
module vic_ctrl_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [31:0] src_in,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [8:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic [31:0] rdata,
   input wire logic        normal_request_n,
   input wire logic        fast_request_n,
   input wire logic        wake_up
);
   logic        wg_q;
   logic        protect_mode_bit_q;
   logic        global_mask_bit_q;
   logic [31:0] svr0_q;
   logic [31:0] spu_q;
   logic [31:0] ff_q;
   logic        wok;
   logic        guarded;
   assign wok     = wr_en && !wg_q;
   assign guarded = addr < 9'h100 || addr == `VIC_OFS_SPU
                    || addr == `VIC_OFS_DBG;
   // shadows of the registers the assertions lean on
   always_ff @(posedge clk) begin
      if (rst) begin
         wg_q   <= 1'b0;
         protect_mode_bit_q <= 1'b0;
         global_mask_bit_q <= 1'b0;
         svr0_q <= 32'h0000_0000;
         spu_q  <= 32'h0000_0000;
         ff_q   <= 32'h0000_0000;
      end else begin
         if (wr_en && addr == `VIC_OFS_WGMODE) wg_q <= wdata[0];
         if (wok && addr == `VIC_OFS_DBG) protect_mode_bit_q <= wdata[0];
         if (wok && addr == `VIC_OFS_DBG) global_mask_bit_q <= wdata[1];
         if (wok && addr == `VIC_OFS_SVR0) svr0_q <= wdata;
         if (wok && addr == `VIC_OFS_SPU) spu_q <= wdata;
         if (wr_en && addr == `VIC_OFS_FFEN) ff_q <= ff_q | wdata;
         if (wr_en && addr == `VIC_OFS_FFDIS) ff_q <= ff_q & ~wdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_lines_idle: assert property ($fell(rst) |-> normal_request_n
      && fast_request_n && !wake_up && rdata == 32'h0000_0000)
      else $error("outputs not idle after reset");
   a_mask_holds_lines: assert property (
      global_mask_bit_q && $past(global_mask_bit_q) |-> normal_request_n && fast_request_n)
      else $error("request line active under global mask");
   a_fast_vec_zero: assert property (
      rd_en && addr == `VIC_OFS_FVR |=> rdata == svr0_q)
      else $error("fast vector not source zero");
   a_spurious_held: assert property (
      rd_en && addr == `VIC_OFS_SPU |=> rdata == spu_q)
      else $error("spurious vector wrong");
   a_force_status: assert property (
      rd_en && addr == `VIC_OFS_FFST |=> rdata == ff_q)
      else $error("forcing status wrong");
   a_status_clears: assert property (
      (rd_en && addr == `VIC_OFS_WGSTAT) ##1 !wr_en
      ##1 (rd_en && addr == `VIC_OFS_WGSTAT) |=> !rdata[0])
      else $error("violation flag not cleared by read");
   a_guard_records: assert property (
      (wg_q && wr_en && guarded) ##2 (rd_en && addr == `VIC_OFS_WGSTAT)
      |=> rdata[0] && rdata[16:8] == $past(addr, 3))
      else $error("violation not recorded");
   a_protect_read_keep: assert property (
      protect_mode_bit_q && rd_en && addr == `VIC_OFS_NVR && !normal_request_n
      && $stable(src_in) |=> !normal_request_n)
      else $error("protect read acknowledged");
   a_normal_read_ack: assert property (
      !protect_mode_bit_q && rd_en && addr == `VIC_OFS_NVR && !normal_request_n
      |=> normal_request_n)
      else $error("vector read left request active");
   c_protect_read: cover property (protect_mode_bit_q && rd_en && addr == `VIC_OFS_NVR);
   c_guard_hit: cover property (wg_q && wr_en && guarded);
   c_fast_req: cover property (!fast_request_n && ff_q != 32'h0000_0000);
endmodule : vic_ctrl_checker
bind vic_ctrl vic_ctrl_checker u_vic_ctrl_checker (.clk(clk), .rst(rst),
   .src_in(src_in), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
   .wdata(wdata), .rdata(rdata), .normal_request_n(normal_request_n),
   .fast_request_n(fast_request_n), .wake_up(wake_up));

//--- tb/vic_core_model.sv
`timescale 1ns/10ps
module vic_core_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic normal_request_n,
   input  wire logic fast_request_n,
   output logic      irq_taken_q,
   output logic      fiq_taken_q
);
   // core samples the active-low lines once per cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_taken_q <= 1'b0;
         fiq_taken_q <= 1'b0;
      end else begin
         irq_taken_q <= !normal_request_n;
         fiq_taken_q <= !fast_request_n;
      end
   end
endmodule : vic_core_model

//--- tb/tb_top.sv
`timescale 1ns/10ps
`include "vic_defines.svh"
module tb_top;
   logic        clk;
   logic        rst;
   logic [31:0] src_in;
   logic        wr_en;
   logic        rd_en;
   logic [8:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        normal_request_n;
   logic        fast_request_n;
   logic        wake_up;
   logic        irq_taken_q;
   logic        fiq_taken_q;
   int          mismatches;
   int          compares;
   int          cycles;
   logic [31:0] r;
   logic [31:0] p0;
   logic [8:0]  gl[4] = '{9'h000, 9'h0FC, 9'h134, 9'h138};
   vic_ctrl u_vic_ctrl (.clk(clk), .rst(rst), .src_in(src_in),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .rdata(rdata), .normal_request_n(normal_request_n),
      .fast_request_n(fast_request_n), .wake_up(wake_up));
   vic_core_model u_vic_core_model (.clk(clk), .rst(rst),
      .normal_request_n(normal_request_n), .fast_request_n(fast_request_n),
      .irq_taken_q(irq_taken_q), .fiq_taken_q(fiq_taken_q));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end
   task automatic final_report;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      wr_en = 1'b1;
      addr  = a;
      wdata = d;
      @(posedge clk);
      #1 wr_en = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [31:0] d);
      rd_en = 1'b1;
      addr  = a;
      @(posedge clk);
      #1 rd_en = 1'b0;
      d = rdata;
      @(posedge clk);
      #1;
   endtask : rd
   task automatic rchk(input logic [8:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(e, d);
   endtask : rchk
   task automatic wait_core(input logic i, input logic f);
      for (int n = 0;
           n < 16 && {irq_taken_q, fiq_taken_q} !== {i, f}; n++) begin
         @(posedge clk);
         #1;
      end
      chk({30'h0, i, f}, {30'h0, irq_taken_q, fiq_taken_q});
   endtask : wait_core
   task automatic s_force_level;
      rd(`VIC_OFS_PEND, p0);
      wr(`VIC_OFS_FFEN, 32'h0000_0002);
      rchk(`VIC_OFS_FFST, 32'h0000_0002);
      src_in[1] = 1'b1;
      wait_core(1'b0, 1'b1);
      rd(`VIC_OFS_PEND, r);
      chk({31'h0, p0[0]}, {31'h0, r[0]});
      rchk(`VIC_OFS_FVR, 32'h0000_AAAA);
      rchk(`VIC_OFS_NVR, 32'h0000_5555);
      wr(`VIC_OFS_EOS, 32'h0000_0000);
      wait_core(1'b0, 1'b1);
      wr(`VIC_OFS_FFDIS, 32'h0000_0002);
      rchk(`VIC_OFS_FFST, 32'h0000_0000);
      wait_core(1'b1, 1'b0);
   endtask : s_force_level
   task automatic s_mask;
      wr(`VIC_OFS_DBG, 32'h0000_0002);
      wait_core(1'b0, 1'b0);
      chk(32'h0000_0001, {31'h0, wake_up});
      wr(`VIC_OFS_DBG, 32'h0000_0000);
      wait_core(1'b1, 1'b0);
   endtask : s_mask
   task automatic s_protect;
      wr(`VIC_OFS_DBG, 32'h0000_0001);
      rchk(`VIC_OFS_NVR, 32'h0000_1111);
      rchk(`VIC_OFS_NVR, 32'h0000_1111);
      wait_core(1'b1, 1'b0);
      rchk(`VIC_OFS_CSR, 32'h0000_0000);
      wr(`VIC_OFS_NVR, 32'h0000_0000);
      wait_core(1'b0, 1'b0);
      rchk(`VIC_OFS_CSR, 32'h0000_0001);
      wr(`VIC_OFS_EOS, 32'h0000_0000);
      wait_core(1'b1, 1'b0);
      wr(`VIC_OFS_DBG, 32'h0000_0000);
      rchk(`VIC_OFS_NVR, 32'h0000_1111);
      wait_core(1'b0, 1'b0);
      rchk(`VIC_OFS_CSR, 32'h0000_0001);
      wr(`VIC_OFS_EOS, 32'h0000_0000);
      wait_core(1'b1, 1'b0);
   endtask : s_protect
   task automatic s_edge;
      src_in[1] = 1'b0;
      wait_core(1'b0, 1'b0);
      wr(`VIC_OFS_FFEN, 32'h0000_0004);
      src_in[2] = 1'b1;
      wait_core(1'b0, 1'b1);
      rd(`VIC_OFS_NVR, r);
      wr(`VIC_OFS_EOS, 32'h0000_0000);
      rd(`VIC_OFS_PEND, r);
      chk(32'h0000_0001, {31'h0, r[2]});
      wr(`VIC_OFS_CLR, 32'h0000_0004);
      wait_core(1'b0, 1'b0);
      rd(`VIC_OFS_PEND, r);
      chk(32'h0000_0000, {31'h0, r[2]});
      src_in[2] = 1'b0;
   endtask : s_edge
   task automatic s_fast0;
      wr(`VIC_OFS_IEN, 32'h0000_0001);
      src_in[0] = 1'b0;
      wait_core(1'b0, 1'b1);
      rchk(`VIC_OFS_FVR, 32'h0000_AAAA);
      wait_core(1'b0, 1'b1);
      src_in[0] = 1'b1;
      wait_core(1'b0, 1'b0);
      wr(`VIC_OFS_IDIS, 32'h0000_0001);
   endtask : s_fast0
   task automatic s_guard;
      wr(`VIC_OFS_WGMODE, 32'h0000_0001);
      wr(`VIC_OFS_SVR0, 32'h0000_DEAD);
      rchk(`VIC_OFS_FVR, 32'h0000_AAAA);
      rchk(`VIC_OFS_WGSTAT, 32'h0000_8001);
      rd(`VIC_OFS_WGSTAT, r);
      chk(32'h0000_0000, {31'h0, r[0]});
      foreach (gl[k]) begin
         wr(gl[k], 32'hFFFF_FFFF);
         rd(`VIC_OFS_WGSTAT, r);
         chk({15'h0, gl[k], 8'h01}, {15'h0, r[16:0]});
      end
      rchk(`VIC_OFS_SPU, 32'h0000_5555);
      rchk(`VIC_OFS_DBG, 32'h0000_0000);
      wr(`VIC_OFS_WGMODE, 32'h0000_0000);
   endtask : s_guard
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      src_in = 32'h0000_0001;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 9'h000;
      wdata = 32'h0000_0000;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      wr(9'h004, 32'h0000_0043);
      wr(9'h008, 32'h0000_0061);
      wr(`VIC_OFS_SVR0, 32'h0000_AAAA);
      wr(9'h084, 32'h0000_1111);
      wr(`VIC_OFS_SPU, 32'h0000_5555);
      wr(`VIC_OFS_IEN, 32'h0000_0006);
      s_force_level();
      s_mask();
      s_protect();
      s_edge();
      s_fast0();
      s_guard();
      final_report();
   end
endmodule : tb_top
